// File: logic/sscm_map.vh
`ifndef SSCM_MAP_VH
`define SSCM_MAP_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define SSCM_ADDR_W           8
`define SSCM_OFS_EVENT        8'h00
`define SSCM_OFS_MASK         8'h04
`define SSCM_OFS_STATE        8'h08
`define SSCM_OFS_FORCE        8'h0C

// ****************************************************************
// event and mask field positions
// ****************************************************************
`define SSCM_EV_CARD_STATUS   0
`define SSCM_EV_DETECT_A      1
`define SSCM_EV_DETECT_B      2
`define SSCM_EV_POWER         3
`define SSCM_EV_W             4
`define SSCM_CD_MASK_ON       2'h3

// ****************************************************************
// live state field positions
// ****************************************************************
`define SSCM_ST_CARD_STATUS   0
`define SSCM_ST_DETECT_A      1
`define SSCM_ST_DETECT_B      2
`define SSCM_ST_POWERED       3
`define SSCM_ST_CARD_16       4
`define SSCM_ST_CARD_CB       5
`define SSCM_ST_READY         6
`define SSCM_ST_VCARD_LO      10
`define SSCM_ST_VCARD_HI      13
`define SSCM_ST_SOCK_5V       28
`define SSCM_ST_SOCK_3V       29
`define SSCM_ST_SOCK_XV       30
`define SSCM_ST_SOCK_YV       31

// ****************************************************************
// reset values
// ****************************************************************
`define SSCM_RST_MASK         4'h0
`define SSCM_RST_EVENT        4'h0
`define SSCM_RST_VCARD        4'h0
`define SSCM_RST_SOCK_XY      2'h0
`define SSCM_RST_SOCK_35      2'h3
`define SSCM_RST_DETECT       1'h1
`define SSCM_RST_PIN_LOW      1'h0

`endif

// File: logic/sscm_socket_status_change_mask.v
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "sscm_map.vh"

// Summary of operation
// - event flags keep latching changes whatever the mask bits say.
// - mask bits 31 to 4 ignore writes and read as zero.
// - mask bit 3 lets power-state change flag raise the interrupt.
// - detect mask field bits 2..1; 00 off, 11 on; 01/10 not used.
// - mask bit 0 lets card status change flag raise the interrupt.
// - all mask bits reset to zero, so no source interrupts early.
// - force register bits 31,30 and 13..10 appear in the live state register; bits 3..0 set event flags.
// - card voltage and card type captured only when identification ends, then held.
// - detect line changes during card identification leave state unchanged.
// - live state resets with bits 29,28,2,1 set and 6,0 clear; 6,2,1,0 follow pins after reset.
// - flag sets on change of its state bit; write 1 clears it.
// - any set unmasked flag raises the interrupt; clear stale flags first.
// - card status flag: rising edge for CardBus, both edges for 16-bit.
// - bits 2,1 mirror detect pins, high means empty; bit 3 power.
module sscm_socket_status_change_mask
(
	// clock and reset
	input  wire        clock,
	input  wire        rst,
	// register port
	input  wire [7:0]  address,
	input  wire [31:0] writeData,
	input  wire        writeStrobe,
	input  wire        readStrobe,
	output reg  [31:0] readData,
	// socket pins
	input  wire        cardDetectPinA,
	input  wire        cardDetectPinB,
	input  wire        cardStatusChangePin,
	input  wire        readyPin,
	// socket control logic
	input  wire        socketPowered,
	input  wire        identifying,
	input  wire        cardIsCardBus,
	input  wire [3:0]  cardVoltageSupport,
	// interrupt
	output reg         statusChangeInterrupt
);

	// ****************************************************************
	// helpers
	// ****************************************************************
	function changed;
		input previous;
		input current;
		begin
			changed = previous ^ current;
		end
	endfunction

	function rose;
		input previous;
		input current;
		begin
			rose = ~previous & current;
		end
	endfunction

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	reg [3:0] pinMeta;
	reg [3:0] pinSync;

	always @(posedge clock)
	begin
		if (rst)
		begin
			pinMeta <= {`SSCM_RST_PIN_LOW, `SSCM_RST_PIN_LOW,
				`SSCM_RST_DETECT, `SSCM_RST_DETECT};
			pinSync <= {`SSCM_RST_PIN_LOW, `SSCM_RST_PIN_LOW,
				`SSCM_RST_DETECT, `SSCM_RST_DETECT};
		end
		else
		begin
			pinMeta <= {readyPin, cardStatusChangePin,
				cardDetectPinB, cardDetectPinA};
			pinSync <= pinMeta;
		end
	end

	wire detectASync = pinSync[0];
	wire detectBSync = pinSync[1];
	wire statusSync  = pinSync[2];
	wire readySync   = pinSync[3];

	// ****************************************************************
	// register decode
	// ****************************************************************
	wire writeMask  = writeStrobe && (address == `SSCM_OFS_MASK);
	wire writeEvent = writeStrobe && (address == `SSCM_OFS_EVENT);
	wire writeForce = writeStrobe && (address == `SSCM_OFS_FORCE);

	// ****************************************************************
	// mask register
	// ****************************************************************
	reg [3:0] maskBits;

	always @(posedge clock)
	begin
		if (rst)
			maskBits <= `SSCM_RST_MASK;
		else if (writeMask)
			maskBits <= writeData[3:0];
	end

	wire powerChangeEnable      = maskBits[`SSCM_EV_POWER];
	wire [1:0] cardDetectChangeEnable =
		maskBits[`SSCM_EV_DETECT_B:`SSCM_EV_DETECT_A];
	wire cardStatusChangeEnable = maskBits[`SSCM_EV_CARD_STATUS];

	// ****************************************************************
	// live socket state
	// ****************************************************************
	reg       cardDetectALevel;
	reg       cardDetectBLevel;
	reg       cardStatusLevel;
	reg       readyLevel;
	reg       socketPoweredState;
	reg       identifyingDelayed;
	reg       cardCardBus;
	reg       card16Bit;
	reg [3:0] cardVoltage;
	reg [1:0] forcedSocketXY;
	reg [3:0] forcedCardVoltage;

	wire identifyDone = identifyingDelayed & ~identifying;

	always @(posedge clock)
	begin
		if (rst)
		begin
			cardDetectALevel   <= detectASync;
			cardDetectBLevel   <= detectBSync;
			cardStatusLevel    <= statusSync;
			readyLevel         <= readySync;
			socketPoweredState <= 1'b0;
			identifyingDelayed <= 1'b0;
			cardCardBus        <= 1'b0;
			card16Bit          <= 1'b0;
			cardVoltage        <= `SSCM_RST_VCARD;
			forcedSocketXY     <= `SSCM_RST_SOCK_XY;
			forcedCardVoltage  <= `SSCM_RST_VCARD;
		end
		else
		begin
			if (!identifying)
			begin
				cardDetectALevel <= detectASync;
				cardDetectBLevel <= detectBSync;
			end
			cardStatusLevel    <= statusSync;
			readyLevel         <= readySync;
			socketPoweredState <= socketPowered;
			identifyingDelayed <= identifying;
			if (identifyDone)
			begin
				cardCardBus       <= cardIsCardBus;
				card16Bit         <= ~cardIsCardBus;
				cardVoltage       <= cardVoltageSupport;
				forcedCardVoltage <= `SSCM_RST_VCARD;
			end
			else if (writeForce)
				forcedCardVoltage <= forcedCardVoltage |
					writeData[`SSCM_ST_VCARD_HI:`SSCM_ST_VCARD_LO];
			if (writeForce)
				forcedSocketXY <=
					writeData[`SSCM_ST_SOCK_YV:`SSCM_ST_SOCK_XV];
		end
	end

	reg [31:0] liveState;

	always @*
	begin
		liveState = 32'h0;
		liveState[`SSCM_ST_SOCK_YV:`SSCM_ST_SOCK_XV] = forcedSocketXY;
		liveState[`SSCM_ST_SOCK_3V:`SSCM_ST_SOCK_5V] =
			`SSCM_RST_SOCK_35;
		liveState[`SSCM_ST_VCARD_HI:`SSCM_ST_VCARD_LO] =
			cardVoltage | forcedCardVoltage;
		liveState[`SSCM_ST_READY]       = readyLevel;
		liveState[`SSCM_ST_CARD_CB]     = cardCardBus;
		liveState[`SSCM_ST_CARD_16]     = card16Bit;
		liveState[`SSCM_ST_POWERED]     = socketPoweredState;
		liveState[`SSCM_ST_DETECT_B]    = cardDetectBLevel;
		liveState[`SSCM_ST_DETECT_A]    = cardDetectALevel;
		liveState[`SSCM_ST_CARD_STATUS] = cardStatusLevel;
	end

	// ****************************************************************
	// change detection
	// ****************************************************************
	reg prevDetectA;
	reg prevDetectB;
	reg prevStatus;
	reg prevPowered;

	always @(posedge clock)
	begin
		if (rst)
		begin
			prevDetectA <= detectASync;
			prevDetectB <= detectBSync;
			prevStatus  <= statusSync;
			prevPowered <= 1'b0;
		end
		else
		begin
			prevDetectA <= cardDetectALevel;
			prevDetectB <= cardDetectBLevel;
			prevStatus  <= cardStatusLevel;
			prevPowered <= socketPoweredState;
		end
	end

	wire statusEdge = cardCardBus ?
		rose(prevStatus, cardStatusLevel) :
		changed(prevStatus, cardStatusLevel);

	wire [3:0] eventSet = {
		changed(prevPowered, socketPoweredState),
		changed(prevDetectB, cardDetectBLevel),
		changed(prevDetectA, cardDetectALevel),
		statusEdge} | (writeForce ? writeData[3:0] : 4'h0);

	// ****************************************************************
	// event flags
	// ****************************************************************
	reg  [3:0] eventFlags;
	wire [3:0] eventClear = writeEvent ? writeData[3:0] : 4'h0;
	wire [3:0] next_eventFlags = (eventFlags & ~eventClear) | eventSet;

	always @(posedge clock)
	begin
		if (rst)
			eventFlags <= `SSCM_RST_EVENT;
		else
			eventFlags <= next_eventFlags;
	end

	wire powerChangeFlag        = eventFlags[`SSCM_EV_POWER];
	wire detectBChangeFlag      = eventFlags[`SSCM_EV_DETECT_B];
	wire detectAChangeFlag      = eventFlags[`SSCM_EV_DETECT_A];
	wire cardStatusChangeFlag   = eventFlags[`SSCM_EV_CARD_STATUS];
	wire detectEnabled =
		(cardDetectChangeEnable == `SSCM_CD_MASK_ON);

	// ****************************************************************
	// interrupt output
	// ****************************************************************
	wire next_statusChangeInterrupt =
		(powerChangeFlag & powerChangeEnable) |
		((detectAChangeFlag | detectBChangeFlag) & detectEnabled) |
		(cardStatusChangeFlag & cardStatusChangeEnable);

	always @(posedge clock)
	begin
		if (rst)
			statusChangeInterrupt <= 1'b0;
		else
			statusChangeInterrupt <=
				next_statusChangeInterrupt;
	end

	// ****************************************************************
	// read port
	// ****************************************************************
	reg [31:0] next_readData;

	always @*
	begin
		next_readData = 32'h0;
		case (address)
			`SSCM_OFS_EVENT:
				next_readData = {28'h0, eventFlags};
			`SSCM_OFS_MASK:
				next_readData = {28'h0, maskBits};
			`SSCM_OFS_STATE:
				next_readData = liveState;
			default:
				next_readData = 32'h0;
		endcase
	end

	always @(posedge clock)
	begin
		if (rst)
			readData <= 32'h0;
		else if (readStrobe)
			readData <= next_readData;
		else
			readData <= 32'h0;
	end

endmodule // sscm_socket_status_change_mask

// File: verification/sscm_card_model.sv
`timescale 1ns/1ps
// card in the socket; detect pins pulled up, status and ready pulled down
module sscm_card_model
(
	// commands from bench
	input  wire present,
	input  wire statusLevel,
	input  wire readyLevel,
	// socket pins
	output wire detectA,
	output wire detectB,
	output wire statusPin,
	output wire readyPin
);
	assign detectA = !present;
	assign detectB = !present;
	assign statusPin = present && statusLevel;
	assign readyPin = present && readyLevel;
endmodule // sscm_card_model

// File: verification/sscm_checker_assertions.sv
`timescale 1ns/1ps
module sscm_checker
(
	// clock and reset
	input wire        clock,
	input wire        rst,
	// register port
	input wire [7:0]  address,
	input wire [31:0] writeData,
	input wire        writeStrobe,
	input wire        readStrobe,
	input wire [31:0] readData,
	// socket control and interrupt
	input wire        socketPowered,
	input wire        statusChangeInterrupt
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire rdMask = readStrobe && address == 8'h04;
	wire rdState = readStrobe && address == 8'h08;
	wire wrMask = writeStrobe && address == 8'h04;
	wire wrForce = writeStrobe && address == 8'h0C;
	AST_MASK_RSVD: assert property ($past(rdMask) |->
		readData[31:4] == 28'h0) else $error("mask upper bits set");
	AST_STATE_SOCK: assert property ($past(rdState) |->
		readData[29:28] == 2'h3) else $error("socket supply bits wrong");
	AST_STATE_RSVD: assert property ($past(rdState) |->
		readData[26:14] == 13'h0) else $error("state reserved bits set");
	AST_STATE_POWER: assert property ($past(rdState) &&
		$stable(socketPowered) && $past(socketPowered, 2) == socketPowered
		|-> readData[3] == socketPowered) else $error("power bit wrong");
	AST_RESET_QUIET: assert property ($fell(rst) |->
		!statusChangeInterrupt [*3]) else $error("irq after reset");
	AST_MASK_OFF: assert property ($past(wrMask &&
		writeData[3:0] == 4'h0, 2) |-> !statusChangeInterrupt)
		else $error("irq with mask off");
	AST_IRQ_HOLD: assert property (statusChangeInterrupt &&
		!writeStrobe && !$past(writeStrobe) |=> statusChangeInterrupt)
		else $error("irq dropped without write");
	AST_FORCE_IRQ: assert property (wrMask && writeData[3:0] == 4'hF ##2
		wrForce && writeData[3:0] == 4'hF |-> ##[1:3] statusChangeInterrupt)
		else $error("forced flag gave no irq");
endmodule // sscm_checker

bind sscm_socket_status_change_mask sscm_checker sscm_checker_inst (
	.clock(clock), .rst(rst), .address(address), .writeData(writeData),
	.writeStrobe(writeStrobe), .readStrobe(readStrobe),
	.readData(readData), .socketPowered(socketPowered),
	.statusChangeInterrupt(statusChangeInterrupt));

// File: verification/tb_sscm_socket_status_change_mask.sv
`timescale 1ns/1ps
module tb_sscm_socket_status_change_mask;
	logic        clock, rst, writeStrobe, readStrobe, irq;
	logic        socketPowered, identifying, cardIsCardBus;
	logic        present, statusLevel, readyLevel;
	logic        detectA, detectB, statusPin, readyPin;
	logic [7:0]  address;
	logic [31:0] writeData, readData;
	logic [3:0]  cardVoltageSupport;
	int          n_errors, checked, cycles;

	sscm_card_model sscm_card_model_inst (.present(present),
		.statusLevel(statusLevel), .readyLevel(readyLevel),
		.detectA(detectA), .detectB(detectB), .statusPin(statusPin),
		.readyPin(readyPin));
	sscm_socket_status_change_mask sscm_socket_status_change_mask_inst (
		.clock(clock), .rst(rst), .address(address),
		.writeData(writeData), .writeStrobe(writeStrobe),
		.readStrobe(readStrobe), .readData(readData),
		.cardDetectPinA(detectA), .cardDetectPinB(detectB),
		.cardStatusChangePin(statusPin), .readyPin(readyPin),
		.socketPowered(socketPowered), .identifying(identifying),
		.cardIsCardBus(cardIsCardBus),
		.cardVoltageSupport(cardVoltageSupport),
		.statusChangeInterrupt(irq));

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ****************
	// tasks
	// ****************
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		writeStrobe <= 1'b1;
		address <= a;
		writeData <= d;
		@(posedge clock);
		writeStrobe <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		readStrobe <= 1'b1;
		address <= a;
		@(posedge clock);
		readStrobe <= 1'b0;
		#1 chk(readData, e);
	endtask
	task irqIs(input logic e);
		#1 chk({31'h0, irq}, {31'h0, e});
	endtask
	task tally_and_finish;
		if (n_errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 1000)
		begin
			n_errors++;
			tally_and_finish();
		end
	end

	// ****************
	// tests
	// ****************
	initial
	begin
		{rst, address, writeData, writeStrobe, readStrobe} = {1'b1, 42'h0};
		{socketPowered, identifying, cardIsCardBus} = 3'h0;
		{cardVoltageSupport, present, statusLevel, readyLevel} = 7'h00;
		n_errors = 0;
		checked = 0;
		cycles = 0;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h30000006);
		irqIs(1'b0);
		wr(8'h04, 32'hFFFFFFF0);
		rd(8'h04, 32'h0);
		rd(8'h10, 32'h0);
		@(posedge clock);
		identifying <= 1;
		cardIsCardBus <= 1;
		cardVoltageSupport <= 4'h5;
		repeat (2) @(posedge clock);
		present <= 1;
		repeat (8) @(posedge clock);
		rd(8'h08, 32'h30000006);
		@(posedge clock);
		identifying <= 0;
		repeat (6) @(posedge clock);
		rd(8'h08, 32'h30001420);
		rd(8'h00, 32'h6);
		irqIs(1'b0);
		@(posedge clock);
		cardVoltageSupport <= 4'hA;
		repeat (4) @(posedge clock);
		rd(8'h08, 32'h30001420);
		wr(8'h04, 32'h6);
		repeat (3) @(posedge clock);
		irqIs(1'b1);
		wr(8'h00, 32'h6);
		repeat (3) @(posedge clock);
		irqIs(1'b0);
		rd(8'h00, 32'h0);
		wr(8'h04, 32'h1);
		statusLevel <= 1;
		repeat (6) @(posedge clock);
		rd(8'h00, 32'h1);
		irqIs(1'b1);
		wr(8'h00, 32'h1);
		statusLevel <= 0;
		repeat (6) @(posedge clock);
		rd(8'h00, 32'h0);
		irqIs(1'b0);
		wr(8'h04, 32'h8);
		socketPowered <= 1;
		readyLevel <= 1;
		repeat (6) @(posedge clock);
		irqIs(1'b1);
		rd(8'h00, 32'h8);
		wr(8'h0C, 32'hC0003C00);
		rd(8'h08, 32'hF0003C68);
		wr(8'h00, 32'hF);
		wr(8'h04, 32'hF);
		wr(8'h0C, 32'hF);
		repeat (4) @(posedge clock);
		irqIs(1'b1);
		// mid-run reset with masks and flags set
		@(posedge clock);
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		rd(8'h04, 32'h0);
		irqIs(1'b0);
		repeat (4) @(posedge clock);
		rd(8'h00, 32'hE);
		irqIs(1'b0);
		wr(8'h04, 32'hF);
		repeat (2) @(posedge clock);
		irqIs(1'b1);
		wr(8'h04, 32'h0);
		repeat (2) @(posedge clock);
		irqIs(1'b0);
		// 16-bit card: status flag on both edges
		wr(8'h00, 32'hF);
		@(posedge clock);
		identifying <= 1'b1;
		cardIsCardBus <= 1'b0;
		repeat (4) @(posedge clock);
		identifying <= 1'b0;
		repeat (4) @(posedge clock);
		rd(8'h08, 32'h30002858);
		wr(8'h04, 32'h1);
		statusLevel <= 1'b1;
		repeat (6) @(posedge clock);
		irqIs(1'b1);
		wr(8'h00, 32'h1);
		statusLevel <= 1'b0;
		repeat (6) @(posedge clock);
		rd(8'h00, 32'h1);
		irqIs(1'b1);
		tally_and_finish();
	end
endmodule // tb_sscm_socket_status_change_mask
